// >>> rtl/dvm_monitor.sv
// direct-memory input mode and solenoid valve overactive monitor
// Contract
// - a parameter write may select direct mode but no parameter path writes the direct value.
// - changing the source select never clears the stored direct value.
// - source select at index 0x010F codes 0 normal, 1 preset, 2 direct.
// - input process data packs set pressure, controlled pressure, flags, code, mode and run.
// - the direct value drives regulation only while the select equals 2.
// - in direct mode regulation runs whatever the output run bit says.
// - index 0x0400 counts whole hours with the reported run bit at 1.
// - index 0x0401 counts hours of supply valve overactive state.
// - index 0x0403 counts hours of exhaust valve overactive state.
// - indices 0x0402 and 0x0404 count entries into the overactive state per valve.
// - the four valve overactive accumulators are saved to retained storage when the output run bit falls; energized hours are not.
// - while a valve is overactive the warning flag is set and its error code shown; with both overactive the supply code is shown.
// - detailed status holds event code 0x8D10 or 0x8D11 for supply or exhaust.
// - an overactive state never stops or alters regulation.
// - select 0 takes pressure from output data, 1 from a preset, 2 from direct memory.
`include "dvm_regs.svh"
`default_nettype none
module dvm_monitor #(
   parameter logic [63:0] HOUR_CYCLES = `DVM_HOUR_CYCLES
)(
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire dvm_pkg::dvm_req_t  req_in,
   output logic [31:0]             rdata_out,
   output logic                    rvalid_out,
   input  wire dvm_pkg::dvm_pdo_t  pdo_in,
   input  wire logic [15:0]        key_direct_in,
   input  wire logic               key_direct_we_in,
   input  wire logic [15:0]        preset_p_in,
   input  wire logic [15:0]        ctrl_p_in,
   input  wire logic [1:0]         sw_out_in,
   input  wire logic               error_in,
   input  wire logic               sup_ovr_pin_in,
   input  wire logic               exh_ovr_pin_in,
   output logic [47:0]             pdi_out,
   output logic [15:0]             target_p_out,
   output logic                    regulate_out,
   output logic                    save_out,
   output logic [127:0]            save_data_out
);
   // registers
   logic [7:0]   src_r,       src_nxt;
   logic [15:0]  direct_r,    direct_nxt;
   logic         run_d_r,     run_d_nxt;
   logic [2:0]   sup_s_r,     sup_s_nxt;
   logic [2:0]   exh_s_r,     exh_s_nxt;
   logic         sup_ov_r,    sup_ov_nxt;
   logic         exh_ov_r,    exh_ov_nxt;
   logic [31:0]  en_hrs_r,    en_hrs_nxt;
   logic [31:0]  sup_hrs_r,   sup_hrs_nxt;
   logic [31:0]  sup_cnt_r,   sup_cnt_nxt;
   logic [31:0]  exh_hrs_r,   exh_hrs_nxt;
   logic [31:0]  exh_cnt_r,   exh_cnt_nxt;
   logic [63:0]  en_tick_r,   en_tick_nxt;
   logic [63:0]  sup_tick_r,  sup_tick_nxt;
   logic [63:0]  exh_tick_r,  exh_tick_nxt;
   logic [31:0]  evt_r,       evt_nxt;
   logic [31:0]  rdata_r,     rdata_nxt;
   logic         rvalid_r,    rvalid_nxt;
   logic [47:0]  pdi_r,       pdi_nxt;
   logic [15:0]  tgt_r,       tgt_nxt;
   logic         reg_r,       reg_nxt;
   logic         save_r,      save_nxt;
   logic [127:0] sdat_r,      sdat_nxt;
   logic         direct_mode;
   logic         run_state;
   logic [3:0]   err_code;

   function automatic logic [31:0] sat_inc(input logic [31:0] v);
      sat_inc = (v >= `DVM_ACC_MAX) ? `DVM_ACC_MAX : v + 32'h00000001;
   endfunction

   // mode decode and reported run state
   assign direct_mode = (src_r[1:0] == `DVM_MODE_DIRECT);
   assign run_state   = pdo_in.run | direct_mode;
   assign err_code    = sup_ov_r ? `DVM_ERR_SUPPLY : (exh_ov_r ? `DVM_ERR_EXHAUST : 4'h0);

   // parameter access, mode select, direct memory
   always_comb
   begin
      src_nxt    = src_r;
      direct_nxt = direct_r;
      rdata_nxt  = rdata_r;
      rvalid_nxt = 1'b0;
      if (req_in.wr && req_in.index == `DVM_IDX_SRC_SELECT && req_in.wdata[7:0] <= 8'h02)
      begin
         src_nxt = req_in.wdata[7:0];
      end
      if (key_direct_we_in)
      begin
         direct_nxt = key_direct_in;
      end
      if (req_in.rd)
      begin
         rvalid_nxt = 1'b1;
         unique case (req_in.index)
            `DVM_IDX_DETAIL_STATUS: rdata_nxt = evt_r;
            `DVM_IDX_SRC_SELECT:    rdata_nxt = {24'h000000, src_r};
            `DVM_IDX_ENERGIZED_HRS: rdata_nxt = en_hrs_r;
            `DVM_IDX_SUP_OVR_HRS:   rdata_nxt = sup_hrs_r;
            `DVM_IDX_SUP_OVR_CNT:   rdata_nxt = sup_cnt_r;
            `DVM_IDX_EXH_OVR_HRS:   rdata_nxt = exh_hrs_r;
            `DVM_IDX_EXH_OVR_CNT:   rdata_nxt = exh_cnt_r;
            default:                rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // valve pin synchronisers, hour and event accumulators
   always_comb
   begin
      sup_s_nxt    = {sup_s_r[1:0], sup_ovr_pin_in};
      exh_s_nxt    = {exh_s_r[1:0], exh_ovr_pin_in};
      sup_ov_nxt   = (sup_s_r[1] == sup_s_r[2]) ? sup_s_r[2] : sup_ov_r;
      exh_ov_nxt   = (exh_s_r[1] == exh_s_r[2]) ? exh_s_r[2] : exh_ov_r;
      en_hrs_nxt   = en_hrs_r;
      sup_hrs_nxt  = sup_hrs_r;
      exh_hrs_nxt  = exh_hrs_r;
      sup_cnt_nxt  = sup_cnt_r;
      exh_cnt_nxt  = exh_cnt_r;
      en_tick_nxt  = en_tick_r;
      sup_tick_nxt = sup_tick_r;
      exh_tick_nxt = exh_tick_r;
      evt_nxt      = evt_r;
      if (run_state)
      begin
         en_tick_nxt = en_tick_r + 64'h1;
         if (en_tick_r + 64'h1 >= HOUR_CYCLES)
         begin
            en_tick_nxt = 64'h0;
            en_hrs_nxt  = sat_inc(en_hrs_r);
         end
      end
      if (sup_ov_r)
      begin
         sup_tick_nxt = sup_tick_r + 64'h1;
         if (sup_tick_r + 64'h1 >= HOUR_CYCLES)
         begin
            sup_tick_nxt = 64'h0;
            sup_hrs_nxt  = sat_inc(sup_hrs_r);
         end
      end
      if (exh_ov_r)
      begin
         exh_tick_nxt = exh_tick_r + 64'h1;
         if (exh_tick_r + 64'h1 >= HOUR_CYCLES)
         begin
            exh_tick_nxt = 64'h0;
            exh_hrs_nxt  = sat_inc(exh_hrs_r);
         end
      end
      if (sup_ov_nxt && !sup_ov_r)
      begin
         sup_cnt_nxt = sat_inc(sup_cnt_r);
         evt_nxt     = `DVM_EVT_SUPPLY;
      end
      if (exh_ov_nxt && !exh_ov_r)
      begin
         exh_cnt_nxt = sat_inc(exh_cnt_r);
         evt_nxt     = `DVM_EVT_EXHAUST;
      end
   end

   // regulation target, process data in, save on run fall
   always_comb
   begin
      run_d_nxt = pdo_in.run;
      unique case (src_r[1:0])
         `DVM_MODE_DIRECT: tgt_nxt = direct_r;
         `DVM_MODE_PRESET: tgt_nxt = preset_p_in;
         default:          tgt_nxt = pdo_in.set_p;
      endcase
      reg_nxt = run_state;
      pdi_nxt = 48'h000000000000;
      pdi_nxt[47:`DVM_PDI_SETP_LSB]              = tgt_nxt;
      pdi_nxt[31:`DVM_PDI_CTRL_LSB]              = ctrl_p_in;
      pdi_nxt[`DVM_PDI_ERR_BIT]                  = error_in;
      pdi_nxt[`DVM_PDI_WARN_BIT]                 = sup_ov_r | exh_ov_r;
      pdi_nxt[`DVM_PDI_NORM_BIT]                 = ~error_in;
      pdi_nxt[`DVM_PDI_SW_LSB+1:`DVM_PDI_SW_LSB] = sw_out_in;
      pdi_nxt[`DVM_PDI_CODE_LSB+3:`DVM_PDI_CODE_LSB] = err_code;
      pdi_nxt[`DVM_PDI_MODE_LSB+1:`DVM_PDI_MODE_LSB] = src_r[1:0];
      pdi_nxt[`DVM_PDI_RUN_BIT]                  = run_state;
      save_nxt = run_d_r & ~pdo_in.run;
      sdat_nxt = save_nxt ? {exh_cnt_r, exh_hrs_r, sup_cnt_r, sup_hrs_r} : sdat_r;
   end

   // state registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         src_r <= `DVM_SRC_RESET;
         direct_r <= 16'h0000;
         run_d_r <= 1'b0;
         sup_s_r <= 3'h0;
         exh_s_r <= 3'h0;
         sup_ov_r <= 1'b0;
         exh_ov_r <= 1'b0;
         en_hrs_r <= 32'h00000000;
         sup_hrs_r <= 32'h00000000;
         sup_cnt_r <= 32'h00000000;
         exh_hrs_r <= 32'h00000000;
         exh_cnt_r <= 32'h00000000;
         en_tick_r <= 64'h0;
         sup_tick_r <= 64'h0;
         exh_tick_r <= 64'h0;
         evt_r <= 32'h00000000;
         rdata_r <= 32'h00000000;
         rvalid_r <= 1'b0;
         pdi_r <= 48'h000000000000;
         tgt_r <= 16'h0000;
         reg_r <= 1'b0;
         save_r <= 1'b0;
         sdat_r <= 128'h0;
      end
      else
      begin
         src_r <= src_nxt;
         direct_r <= direct_nxt;
         run_d_r <= run_d_nxt;
         sup_s_r <= sup_s_nxt;
         exh_s_r <= exh_s_nxt;
         sup_ov_r <= sup_ov_nxt;
         exh_ov_r <= exh_ov_nxt;
         en_hrs_r <= en_hrs_nxt;
         sup_hrs_r <= sup_hrs_nxt;
         sup_cnt_r <= sup_cnt_nxt;
         exh_hrs_r <= exh_hrs_nxt;
         exh_cnt_r <= exh_cnt_nxt;
         en_tick_r <= en_tick_nxt;
         sup_tick_r <= sup_tick_nxt;
         exh_tick_r <= exh_tick_nxt;
         evt_r <= evt_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         pdi_r <= pdi_nxt;
         tgt_r <= tgt_nxt;
         reg_r <= reg_nxt;
         save_r <= save_nxt;
         sdat_r <= sdat_nxt;
      end
   end

   // outputs
   assign rdata_out     = rdata_r;
   assign rvalid_out    = rvalid_r;
   assign pdi_out       = pdi_r;
   assign target_p_out  = tgt_r;
   assign regulate_out  = reg_r;
   assign save_out      = save_r;
   assign save_data_out = sdat_r;

   // checks
   property p_src_write;
      @(posedge clk_in) disable iff (rst_in)
      req_in.wr && req_in.index == `DVM_IDX_SRC_SELECT && req_in.wdata[7:0] == 8'h02
      |=> pdi_out[3:2] == 2'h2 || src_r[1:0] == 2'h2;
   endproperty
   a_src_write: assert property (p_src_write) else $error("select write lost");
   property p_direct_keep;
      @(posedge clk_in) disable iff (rst_in)
      req_in.wr && !key_direct_we_in |=> direct_r == $past(direct_r);
   endproperty
   a_direct_keep: assert property (p_direct_keep) else $error("direct value changed");
   property p_direct_target;
      @(posedge clk_in) disable iff (rst_in)
      src_r[1:0] == 2'h2 && !key_direct_we_in |=> target_p_out == $past(direct_r);
   endproperty
   a_direct_target: assert property (p_direct_target) else $error("direct target wrong");
   property p_direct_run;
      @(posedge clk_in) disable iff (rst_in)
      src_r[1:0] == 2'h2 |=> regulate_out && pdi_out[0];
   endproperty
   a_direct_run: assert property (p_direct_run) else $error("direct not regulating");
   property p_save;
      @(posedge clk_in) disable iff (rst_in)
      $fell(pdo_in.run) |=> save_out ##1 !save_out;
   endproperty
   a_save: assert property (p_save) else $error("save pulse wrong");
   property p_warn;
      @(posedge clk_in) disable iff (rst_in)
      sup_ov_r |=> pdi_out[14] && pdi_out[7:4] == 4'hA;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not shown");
   property p_event;
      @(posedge clk_in) disable iff (rst_in)
      $rose(exh_ov_r) |-> evt_r == 32'h00008D11;
   endproperty
   a_event: assert property (p_event) else $error("event code wrong");
   property p_count;
      @(posedge clk_in) disable iff (rst_in)
      $rose(sup_ov_r) && $past(sup_cnt_r) < `DVM_ACC_MAX
      |-> sup_cnt_r == $past(sup_cnt_r) + 32'h00000001;
   endproperty
   a_count: assert property (p_count) else $error("entry not counted");
   property p_sat;
      @(posedge clk_in) disable iff (rst_in)
      en_hrs_r <= `DVM_ACC_MAX && sup_hrs_r <= `DVM_ACC_MAX && sup_cnt_r <= `DVM_ACC_MAX
      && exh_hrs_r <= `DVM_ACC_MAX && exh_cnt_r <= `DVM_ACC_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("accumulator over range");
endmodule
`default_nettype wire

// >>> rtl/dvm_regs.svh
// register offsets, field positions, codes and timing counts of the direct mode / valve monitor
`ifndef DVM_REGS_SVH
`define DVM_REGS_SVH
`define DVM_IDX_DETAIL_STATUS 16'h0025
`define DVM_IDX_SRC_SELECT    16'h010F
`define DVM_IDX_ENERGIZED_HRS 16'h0400
`define DVM_IDX_SUP_OVR_HRS   16'h0401
`define DVM_IDX_SUP_OVR_CNT   16'h0402
`define DVM_IDX_EXH_OVR_HRS   16'h0403
`define DVM_IDX_EXH_OVR_CNT   16'h0404
`define DVM_MODE_NORMAL       2'h0
`define DVM_MODE_PRESET       2'h1
`define DVM_MODE_DIRECT       2'h2
`define DVM_SRC_RESET         8'h00
`define DVM_ACC_MAX           32'h0098967F
`define DVM_EVT_SUPPLY        32'h00008D10
`define DVM_EVT_EXHAUST       32'h00008D11
`define DVM_ERR_SUPPLY        4'hA
`define DVM_ERR_EXHAUST       4'hB
`define DVM_PDI_SETP_LSB      32
`define DVM_PDI_CTRL_LSB      16
`define DVM_PDI_ERR_BIT       15
`define DVM_PDI_WARN_BIT      14
`define DVM_PDI_NORM_BIT      13
`define DVM_PDI_SW_LSB        8
`define DVM_PDI_CODE_LSB      4
`define DVM_PDI_MODE_LSB      2
`define DVM_PDI_RUN_BIT       0
`define DVM_HOUR_S            3600
`define DVM_CLK_HZ            250000000
`define DVM_HOUR_CYCLES       (64'd3600 * 64'd250000000)
`endif

// >>> rtl/dvm_pkg.sv
// types shared by the direct mode / valve monitor
`default_nettype none
package dvm_pkg;
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [15:0] index;
      logic [31:0] wdata;
   } dvm_req_t;
   typedef struct packed
   {
      logic [15:0] set_p;
      logic        run;
   } dvm_pdo_t;
endpackage
`default_nettype wire

// >>> verification/dvm_master_model.sv
// behavioural io-link master: parameter requests and output process data
`default_nettype none
module dvm_master_model (
   input  wire logic               clk_in,
   input  wire logic               rvalid_in,
   input  wire logic [31:0]        rdata_in,
   output var  dvm_pkg::dvm_req_t  req_out,
   output var  dvm_pkg::dvm_pdo_t  pdo_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle master: no request, stopped, zero set pressure
   initial
   begin
      req_out = '0;
      pdo_out = '0;
   end
   // one request pulse, then a bounded wait for the read answer
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic ok);
      @(negedge clk_in);
      req_out = '{wr, ~wr, idx, wd};
      @(negedge clk_in);
      req_out.wr = 1'b0;
      req_out.rd = 1'b0;
      ok = wr | rvalid_in;
      rdv = rdata_in;
      for (int n = 0; n < 3 && ok !== 1'b1; n++)
      begin
         @(negedge clk_in);
         ok = rvalid_in;
         rdv = rdata_in;
      end
      // released lines do not keep their last value
      req_out.index = ~idx;
      req_out.wdata = ~wd;
   endtask
   // cyclic output data from the master
   task automatic set_pdo(input logic [15:0] sp, input logic run);
      pdo_out.set_p = sp;
      pdo_out.run = run;
   endtask
   // orderly stop before power removal
   task automatic shutdown();
      @(negedge clk_in);
      pdo_out.set_p = 16'h0000;
      @(negedge clk_in);
      pdo_out.run = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench of the direct mode and valve overactive monitor
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] md; logic [15:0] sp; logic run; logic err; logic [1:0] sw;
      logic [15:0] tgt;} dvm_row_t;
   logic              clk_in = 1'b0;
   logic              rst_in = 1'b1;
   dvm_pkg::dvm_req_t req_in;
   dvm_pkg::dvm_pdo_t pdo_in;
   logic [31:0]       rdata_out, v, a;
   logic [31:0]       cnt [2];
   logic              rvalid_out, regulate_out, save_out, key_direct_we_in = 1'b0;
   logic [15:0]       key_direct_in = 16'h0789, preset_p_in = 16'h0456, ctrl_p_in = 16'h0000;
   logic [1:0]        sw_out_in = 2'h0;
   logic              error_in = 1'b0, sup_ovr_pin_in = 1'b0, exh_ovr_pin_in = 1'b0;
   logic [47:0]       pdi_out;
   logic [15:0]       target_p_out;
   logic [127:0]      save_data_out;
   int                miscompares = 0;
   int                n_compared = 0;
   localparam logic [47:0] MASK = 48'hFFFF_FFFF_E3FD;
   dvm_row_t rows [5] = '{
      '{2'h0, 16'h1234, 1'b1, 1'b0, 2'h1, 16'h1234},
      '{2'h1, 16'h1234, 1'b1, 1'b1, 2'h2, 16'h0456},
      '{2'h2, 16'h1234, 1'b0, 1'b0, 2'h3, 16'h0789},
      '{2'h0, 16'h2222, 1'b0, 1'b0, 2'h0, 16'h2222},
      '{2'h2, 16'h3333, 1'b0, 1'b1, 2'h1, 16'h0789}};
   // 250 MHz clock
   always #2 clk_in = ~clk_in;
   dvm_master_model mst (.clk_in, .rvalid_in(rvalid_out), .rdata_in(rdata_out),
      .req_out(req_in), .pdo_out(pdo_in));
   dvm_monitor #(.HOUR_CYCLES(64'h000000000000000A)) uut (.clk_in, .rst_in, .req_in,
      .rdata_out, .rvalid_out, .pdo_in, .key_direct_in, .key_direct_we_in, .preset_p_in,
      .ctrl_p_in, .sw_out_in, .error_in, .sup_ovr_pin_in, .exh_ovr_pin_in, .pdi_out,
      .target_p_out, .regulate_out, .save_out, .save_data_out);
   // verdict and end of run
   task automatic final_report();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // exact value comparison
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // hour count comparison within a window
   task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] g);
      n_compared++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         miscompares++;
         $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, g);
      end
   endtask
   // parameter read, a missing answer ends the run
   task automatic rd(input logic [15:0] idx, output logic [31:0] d);
      logic ok;
      mst.xfer(1'b0, idx, 32'h0, d, ok);
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("ERROR read %h expected answer seen none", idx);
         final_report();
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] x;
      logic ok;
      mst.xfer(1'b1, idx, d, x, ok);
   endtask
   function automatic logic [47:0] exp_pdi(input dvm_row_t r, input logic [15:0] c);
      return {r.tgt, c, r.err, 1'b0, ~r.err, 3'h0, r.sw, 4'h0, r.md, 1'b0, r.run | r.md[1]};
   endfunction
   // main sequence
   initial
   begin
      repeat (6) @(negedge clk_in);
      chk("pdi in reset", 48'h0, pdi_out);
      rst_in = 1'b0;
      // key entry first, so a stray parameter write to the direct value would show
      key_direct_we_in = 1'b1;
      @(negedge clk_in);
      key_direct_we_in = 1'b0;
      // writes to read-only indices must leave them at zero, and a write to 0x0110 must leave the select at zero
      for (int i = 0; i < 6; i++)
      begin
         wr(i < 5 ? 16'h0400 + 16'(i) : 16'h0110, 32'h0000FFFF);
         rd(i < 5 ? 16'h0400 + 16'(i) : 16'h010F, v);
         chk("reset value", 48'h0, {16'h0, v});
      end
      // normal, preset and direct mode rows
      foreach (rows[i])
      begin
         ctrl_p_in = 16'h0100 + 16'(i);
         sw_out_in = rows[i].sw;
         error_in = rows[i].err;
         mst.set_pdo(rows[i].sp, rows[i].run);
         wr(16'h010F, {30'h0, rows[i].md});
         repeat (3) @(negedge clk_in);
         chk("pdi", exp_pdi(rows[i], ctrl_p_in), pdi_out & MASK);
         chk("target", {32'h0, rows[i].tgt}, {32'h0, target_p_out});
         chk("regulate", {47'h0, rows[i].run | rows[i].md[1]}, {47'h0, regulate_out});
         rd(16'h010F, v);
         chk("select", {46'h0, rows[i].md}, {16'h0, v});
      end
      wr(16'h010F, 32'h00000003);
      rd(16'h010F, v);
      chk("refused select", 48'h2, {16'h0, v});
      rd(16'h0200, v);
      chk("unmapped", 48'h0, {16'h0, v});
      rd(16'h0400, a);
      repeat (35) @(negedge clk_in);
      rd(16'h0400, v);
      chk_rng("energized", a + 32'h3, a + 32'h4, v);
      // supply then exhaust valve overactive
      for (int k = 0; k < 2; k++)
      begin
         rd(16'h0402 + 16'(2 * k), cnt[k]);
         rd(16'h0401 + 16'(2 * k), a);
         sup_ovr_pin_in = (k == 0);
         exh_ovr_pin_in = (k == 1);
         repeat (8) @(negedge clk_in);
         chk("warning", {44'h1, 4'hA + 4'(k)}, {43'h0, pdi_out[14], pdi_out[7:4]});
         chk("reg in ovr", {31'h1, 16'h0789}, {31'(regulate_out), target_p_out});
         repeat (17) @(negedge clk_in);
         sup_ovr_pin_in = 1'b0;
         exh_ovr_pin_in = 1'b0;
         repeat (8) @(negedge clk_in);
         chk("warning off", 48'h0, {47'h0, pdi_out[14]});
         cnt[k] = cnt[k] + 32'h1;
         rd(16'h0402 + 16'(2 * k), v);
         chk("ovr count", {16'h0, cnt[k]}, {16'h0, v});
         rd(16'h0401 + 16'(2 * k), v);
         chk_rng("ovr hours", a + 32'h2, a + 32'h3, v);
         rd(16'h0025, v);
         chk("event", 48'h8D10 + 48'(k), {16'h0, v});
      end
      // stop edge saves the valve accumulators
      wr(16'h010F, 32'h0);
      mst.set_pdo(16'h1000, 1'b1);
      mst.shutdown();
      v = 32'h0;
      for (int n = 0; n < 6 && v == 0; n++)
      begin
         @(negedge clk_in);
         if (save_out === 1'b1)
            v = 32'h1;
      end
      chk("save pulse", 48'h1, {16'h0, v});
      chk("save data", {cnt[1], 16'h0}, {save_data_out[127:96], save_data_out[63:48]});
      chk("save sup cnt", {16'h0, cnt[0]}, {16'h0, save_data_out[63:32]});
      rd(16'h0400, a);
      repeat (30) @(negedge clk_in);
      rd(16'h0400, v);
      chk("energized stopped", {16'h0, a}, {16'h0, v});
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      chk("pdi after reset", 48'h0, pdi_out);
      rd(16'h010F, v);
      chk("select after reset", 48'h0, {16'h0, v});
      final_report();
   end
endmodule
`default_nettype wire
